// file: src/sfa_pkg.sv
`default_nettype none
package sfa_pkg;

  // Operand and lane geometry
  localparam int SFA_VEC_W = 128;
  localparam int SFA_SP_W  = 32;
  localparam int SFA_DP_W  = 64;
  localparam int SFA_SP_EW = 8;
  localparam int SFA_SP_MW = 23;
  localparam int SFA_DP_EW = 11;
  localparam int SFA_DP_MW = 52;
  localparam int SFA_SP_LANES = 4;
  localparam int SFA_DP_LANES = 2;

  // Double to integer conversion
  localparam int             SFA_DP_BIAS    = 1023;
  localparam int             SFA_INT_MAXE   = 62;
  localparam int             SFA_FIX_W      = 116;
  localparam int             SFA_FIX_FRAC   = 53;
  localparam logic [63:0]    SFA_INT_INDEF  = 64'h8000_0000_0000_0000;
  localparam logic [10:0]    SFA_DP_EXP_MAX = 11'h7FF;

  // Rounding control field of the fp_control_word
  typedef enum logic [1:0] {
    SFA_RC_NEAR = 2'h0,
    SFA_RC_DOWN = 2'h1,
    SFA_RC_UP   = 2'h2,
    SFA_RC_ZERO = 2'h3
  } sfa_rc_e;

  typedef enum logic [3:0] {
    SFA_OP_ALT_ADDSUB_SINGLE = 4'h0,
    SFA_OP_ALT_ADDSUB_DOUBLE = 4'h1,
    SFA_OP_PAIRWISE_ADD_SGL  = 4'h2,
    SFA_OP_PAIRWISE_SUB_SGL  = 4'h3,
    SFA_OP_PAIRWISE_ADD_DBL  = 4'h4,
    SFA_OP_PAIRWISE_SUB_DBL  = 4'h5,
    SFA_OP_ODD_LANE_DUP      = 4'h6,
    SFA_OP_EVEN_LANE_DUP     = 4'h7,
    SFA_OP_QUAD_DUP          = 4'h8,
    SFA_OP_TRUNC_INT_POP     = 4'h9,
    SFA_OP_INT_STORE_POP     = 4'hA
  } sfa_op_e;

  // Round-increment decision shared by the adders and the converter
  function automatic logic sfa_rnd_inc(input logic [1:0] rm, input logic sgn,
                                       input logic lsb, input logic grd, input logic stk);
    case (rm)
      SFA_RC_NEAR: return grd & (stk | lsb);
      SFA_RC_DOWN: return sgn & (grd | stk);
      SFA_RC_UP:   return ~sgn & (grd | stk);
      default:     return 1'b0;
    endcase
  endfunction

endpackage
`default_nettype wire

// file: src/sfa_fp_add.sv
`timescale 1ns/1ps
`default_nettype none
module sfa_fp_add #(
  parameter int EW = 8,
  parameter int MW = 23
) (
  // Operands
  input  wire logic [EW+MW:0] i_a,
  input  wire logic [EW+MW:0] i_b,
  input  wire logic           i_sub,
  input  wire logic [1:0]     i_rm,
  // Result
  output logic      [EW+MW:0] o_sum
);
  import sfa_pkg::*;

  localparam int W  = EW + MW + 1;
  localparam int FW = MW + 4;
  localparam logic [EW-1:0] EMAX = {EW{1'b1}};

  logic          sa, sb, sx, sy, nan_a, nan_b, inf_a, inf_b, up, stk, rs;
  logic [W-2:0]  mag_x, mag_y;
  logic [EW-1:0] ex, ey, dsh;
  logic [EW+1:0] e;
  logic [FW:0]   mx, my, s;
  logic [MW+1:0] m;

  always_comb begin
    sa    = i_a[W-1];
    sb    = i_b[W-1] ^ i_sub;
    nan_a = (i_a[W-2:MW] == EMAX) && (i_a[MW-1:0] != '0);
    nan_b = (i_b[W-2:MW] == EMAX) && (i_b[MW-1:0] != '0);
    inf_a = (i_a[W-2:MW] == EMAX) && (i_a[MW-1:0] == '0);
    inf_b = (i_b[W-2:MW] == EMAX) && (i_b[MW-1:0] == '0);
    // Larger magnitude drives the result sign and exponent
    if (i_b[W-2:0] > i_a[W-2:0]) begin
      sx = sb; mag_x = i_b[W-2:0]; sy = sa; mag_y = i_a[W-2:0];
    end else begin
      sx = sa; mag_x = i_a[W-2:0]; sy = sb; mag_y = i_b[W-2:0];
    end
    ex  = (mag_x[W-2:MW] == '0) ? EW'(1) : mag_x[W-2:MW];
    ey  = (mag_y[W-2:MW] == '0) ? EW'(1) : mag_y[W-2:MW];
    mx  = {1'b0, mag_x[W-2:MW] != '0, mag_x[MW-1:0], 3'h0};
    my  = {1'b0, mag_y[W-2:MW] != '0, mag_y[MW-1:0], 3'h0};
    dsh = ex - ey;
    stk = |(my & ~({(FW+1){1'b1}} << dsh));
    my  = (my >> dsh) | {{FW{1'b0}}, stk};
    s   = (sx == sy) ? mx + my : mx - my;
    e   = {2'h0, ex};
    if (s[FW]) begin
      s = {1'b0, s[FW:2], s[1] | s[0]};
      e = e + 1'b1;
    end else begin
      for (int k = 0; k < FW; k++) begin
        if (!s[FW-1] && e > 1) begin
          s = s << 1;
          e = e - 1'b1;
        end
      end
    end
    up = sfa_rnd_inc(i_rm, sx, s[3], s[2], |s[1:0]);
    m  = {1'b0, s[FW-1:3]} + {{(MW+1){1'b0}}, up};
    if (m[MW+1]) begin
      m = m >> 1;
      e = e + 1'b1;
    end
    if (!m[MW]) begin
      e = '0;
    end
    // Exact cancellation gives +0, except -0 when rounding down
    rs = (s == '0 && sx != sy) ? (i_rm == SFA_RC_DOWN) : sx;
    if (nan_a) begin
      o_sum = i_a | (W'(1) << (MW-1));
    end else if (nan_b) begin
      o_sum = i_b | (W'(1) << (MW-1));
    end else if (inf_a && inf_b && sa != sb) begin
      o_sum = {1'b1, EMAX, 1'b1, {(MW-1){1'b0}}};
    end else if (inf_a || inf_b) begin
      o_sum = {inf_a ? sa : sb, EMAX, {MW{1'b0}}};
    end else if (e >= {2'h0, EMAX}) begin
      // Overflow saturates to the largest finite value when rounding inward
      if (i_rm == SFA_RC_ZERO || (i_rm == SFA_RC_UP && rs) || (i_rm == SFA_RC_DOWN && !rs))
        o_sum = {rs, EMAX - 1'b1, {MW{1'b1}}};
      else
        o_sum = {rs, EMAX, {MW{1'b0}}};
    end else begin
      o_sum = {rs, e[EW-1:0], m[MW-1:0]};
    end
  end

endmodule
`default_nettype wire

// file: src/sfa_simd_fp_unit.sv
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// RULE_01 - Alternating single op subtracts in lanes 0 and 2 and adds in lanes 1 and 3.
// RULE_02 - Alternating double op subtracts in lane 0 and adds in lane 1.
// RULE_03 - Pairwise single add puts pair sums of A in lanes 0,1 and of B in lanes 2,3.
// RULE_04 - Pairwise single subtract takes low minus high element, A to lanes 0,1, B to 2,3.
// RULE_05 - Pairwise double add gives A0+A1 in lane 0 and B0+B1 in lane 1.
// RULE_06 - Pairwise double subtract gives A0-A1 in lane 0 and B0-B1 in lane 1.
// RULE_07 - Odd duplicate copies source elements 1 and 3 into their own lane and the one below.
// RULE_08 - Even duplicate copies source elements 0 and 2 into their own lane and the one above.
// RULE_09 - Quad duplicate places source bits 63:0 in both halves of the result.
// RULE_10 - Truncating integer store-pop converts like the plain one but always rounds to zero.
// RULE_11 - Lane 0 is the least significant element of each 128-bit operand.
// RULE_12 - Every add or subtract lane gives an IEEE result rounded per the control word.
module sfa_simd_fp_unit (
  // Clock and reset
  input  wire logic                            i_ref_clk,
  input  wire logic                            i_rst_b,
  // Issue
  input  wire logic                            i_issue_valid,
  input  wire sfa_pkg::sfa_op_e                i_op,
  input  wire logic [sfa_pkg::SFA_VEC_W-1:0]   i_src_a,
  input  wire logic [sfa_pkg::SFA_VEC_W-1:0]   i_src_b,
  input  wire logic [1:0]                      i_rnd_ctl,
  // Write-back
  output logic                                 o_wb_valid,
  output logic      [sfa_pkg::SFA_VEC_W-1:0]   o_wb_data,
  output logic                                 o_cvt_invalid
);
  import sfa_pkg::*;

  logic [SFA_SP_W-1:0]  sx_op [SFA_SP_LANES];
  logic [SFA_SP_W-1:0]  sy_op [SFA_SP_LANES];
  logic [SFA_SP_W-1:0]  s_sum [SFA_SP_LANES];
  logic [SFA_DP_W-1:0]  dx_op [SFA_DP_LANES];
  logic [SFA_DP_W-1:0]  dy_op [SFA_DP_LANES];
  logic [SFA_DP_W-1:0]  d_sum [SFA_DP_LANES];
  logic [SFA_SP_LANES-1:0] s_sub;
  logic [SFA_DP_LANES-1:0] d_sub;
  logic [SFA_VEC_W-1:0] pair_src;

  // Operand steering; lane i sits at bits [32*i +: 32]
  always_comb begin
    s_sub    = '0;
    d_sub    = '0;
    pair_src = '0;
    for (int i = 0; i < SFA_SP_LANES; i++) begin
      if (i_op == SFA_OP_ALT_ADDSUB_SINGLE) begin
        sx_op[i] = i_src_a[SFA_SP_W*i +: SFA_SP_W];                       // [RULE_11]
        sy_op[i] = i_src_b[SFA_SP_W*i +: SFA_SP_W];
        s_sub[i] = ((i % 2) == 0);                                         // [RULE_01]
      end else begin
        pair_src = (i < 2) ? i_src_a : i_src_b;                            // [RULE_03]
        sx_op[i] = pair_src[2*SFA_SP_W*(i%2) +: SFA_SP_W];                 // [RULE_04]
        sy_op[i] = pair_src[2*SFA_SP_W*(i%2)+SFA_SP_W +: SFA_SP_W];
        s_sub[i] = (i_op == SFA_OP_PAIRWISE_SUB_SGL);
      end
    end
    for (int j = 0; j < SFA_DP_LANES; j++) begin
      if (i_op == SFA_OP_ALT_ADDSUB_DOUBLE) begin
        dx_op[j] = i_src_a[SFA_DP_W*j +: SFA_DP_W];
        dy_op[j] = i_src_b[SFA_DP_W*j +: SFA_DP_W];
        d_sub[j] = (j == 0);                                               // [RULE_02]
      end else begin
        dx_op[j] = (j == 0) ? i_src_a[SFA_DP_W-1:0] : i_src_b[SFA_DP_W-1:0];   // [RULE_05]
        dy_op[j] = (j == 0) ? i_src_a[2*SFA_DP_W-1:SFA_DP_W]
                            : i_src_b[2*SFA_DP_W-1:SFA_DP_W];
        d_sub[j] = (i_op == SFA_OP_PAIRWISE_SUB_DBL);                      // [RULE_06]
      end
    end
  end

  for (genvar g = 0; g < SFA_SP_LANES; g++) begin : g_sp
    sfa_fp_add #(.EW(SFA_SP_EW), .MW(SFA_SP_MW)) u_add (
      .i_a   (sx_op[g]),
      .i_b   (sy_op[g]),
      .i_sub (s_sub[g]),
      .i_rm  (i_rnd_ctl),                                                  // [RULE_12]
      .o_sum (s_sum[g])
    );
  end
  for (genvar g = 0; g < SFA_DP_LANES; g++) begin : g_dp
    sfa_fp_add #(.EW(SFA_DP_EW), .MW(SFA_DP_MW)) u_add (
      .i_a   (dx_op[g]),
      .i_b   (dy_op[g]),
      .i_sub (d_sub[g]),
      .i_rm  (i_rnd_ctl),
      .o_sum (d_sum[g])
    );
  end

  // Double to 64-bit integer conversion of the low lane of A
  logic                 cv_sign, cv_inc, cv_bad;
  logic [1:0]           cv_rm;
  logic signed [12:0]   cv_exp;
  logic [SFA_FIX_W-1:0] cv_fix;
  logic [62:0]          cv_ip;
  logic                 cv_grd, cv_stk;
  logic [63:0]          cv_mag, cv_res;

  always_comb begin
    cv_sign = i_src_a[SFA_DP_W-1];
    cv_rm   = (i_op == SFA_OP_TRUNC_INT_POP) ? SFA_RC_ZERO : i_rnd_ctl;      // [RULE_10]
    cv_exp  = $signed({2'h0, i_src_a[SFA_DP_W-2:SFA_DP_MW]}) - 13'(SFA_DP_BIAS);
    cv_bad  = (i_src_a[SFA_DP_W-2:SFA_DP_MW] == SFA_DP_EXP_MAX) ||
              (cv_exp > 13'(SFA_INT_MAXE));
    cv_fix  = '0;
    cv_ip   = '0;
    cv_grd  = 1'b0;
    cv_stk  = 1'b0;
    if (cv_exp < -13'sd1) begin
      // Below one half: only stickiness survives
      cv_stk = |i_src_a[SFA_DP_W-2:0];
    end else if (!cv_bad) begin
      cv_fix = {1'b1, i_src_a[SFA_DP_MW-1:0], {(SFA_INT_MAXE+1){1'b0}}}
               >> (13'(SFA_INT_MAXE) - cv_exp);
      cv_ip  = cv_fix[SFA_FIX_W-1:SFA_FIX_FRAC];
      cv_grd = cv_fix[SFA_FIX_FRAC-1];
      cv_stk = |cv_fix[SFA_FIX_FRAC-2:0];
    end
    cv_inc = sfa_rnd_inc(cv_rm, cv_sign, cv_ip[0], cv_grd, cv_stk);        // [RULE_12]
    cv_mag = {1'b0, cv_ip} + {63'h0, cv_inc};
    // Rounding up to 2**63 only fits when negative
    cv_bad = cv_bad || (cv_mag[63] && !(cv_sign && cv_mag == SFA_INT_INDEF));
    cv_res = cv_bad ? SFA_INT_INDEF : (cv_sign ? -cv_mag : cv_mag);
  end

  // Result selection
  logic                 wb_valid_d, wb_valid_q, cvt_inv_d, cvt_inv_q;
  logic [SFA_VEC_W-1:0] wb_data_d, wb_data_q;

  always_comb begin
    wb_valid_d = i_issue_valid;
    wb_data_d  = wb_data_q;
    cvt_inv_d  = 1'b0;
    if (i_issue_valid) begin
      unique case (i_op)
        SFA_OP_ALT_ADDSUB_SINGLE, SFA_OP_PAIRWISE_ADD_SGL, SFA_OP_PAIRWISE_SUB_SGL:
          wb_data_d = {s_sum[3], s_sum[2], s_sum[1], s_sum[0]};
        SFA_OP_ALT_ADDSUB_DOUBLE, SFA_OP_PAIRWISE_ADD_DBL, SFA_OP_PAIRWISE_SUB_DBL:
          wb_data_d = {d_sum[1], d_sum[0]};
        SFA_OP_ODD_LANE_DUP:
          wb_data_d = {i_src_b[127:96], i_src_b[127:96],
                       i_src_b[63:32], i_src_b[63:32]};                   // [RULE_07]
        SFA_OP_EVEN_LANE_DUP:
          wb_data_d = {i_src_b[95:64], i_src_b[95:64],
                       i_src_b[31:0], i_src_b[31:0]};                     // [RULE_08]
        SFA_OP_QUAD_DUP:
          wb_data_d = {i_src_b[63:0], i_src_b[63:0]};                     // [RULE_09]
        SFA_OP_TRUNC_INT_POP, SFA_OP_INT_STORE_POP: begin
          wb_data_d = {64'h0, cv_res};                                     // [RULE_10]
          cvt_inv_d = cv_bad;
        end
        default:
          wb_data_d = '0;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wb_valid_q <= 1'b0;
      wb_data_q  <= '0;
      cvt_inv_q  <= 1'b0;
    end else begin
      wb_valid_q <= wb_valid_d;
      wb_data_q  <= wb_data_d;
      cvt_inv_q  <= cvt_inv_d;
    end
  end

  assign o_wb_valid    = wb_valid_q;
  assign o_wb_data     = wb_data_q;
  assign o_cvt_invalid = cvt_inv_q;

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_b);

  a_alt_single_pattern: assert property ( // [RULE_01]
    i_op == SFA_OP_ALT_ADDSUB_SINGLE |-> s_sub == 4'h5 && sy_op[1] == i_src_b[63:32])
    else $error("alternating single lane pattern wrong");
  a_alt_double_zero: assert property ( // [RULE_02]
    i_issue_valid && i_op == SFA_OP_ALT_ADDSUB_DOUBLE && i_src_b == '0 &&
    i_src_a[62:52] != 11'h0 && i_src_a[62:52] != 11'h7FF &&
    i_src_a[126:116] != 11'h0 && i_src_a[126:116] != 11'h7FF
    |=> o_wb_data == $past(i_src_a))
    else $error("alternating double with zero operand changed A");
  a_pair_add_single: assert property ( // [RULE_03]
    i_issue_valid && i_op == SFA_OP_PAIRWISE_ADD_SGL && i_src_b[63:32] == '0 &&
    i_src_b[30:23] != 8'h0 && i_src_b[30:23] != 8'hFF
    |=> o_wb_data[95:64] == $past(i_src_b[31:0]))
    else $error("pairwise single add lane 2 wrong");
  a_pair_sub_single: assert property ( // [RULE_04]
    i_issue_valid && i_op == SFA_OP_PAIRWISE_SUB_SGL && i_src_a[95:64] == '0 &&
    i_src_a[126:119] != 8'h0 && i_src_a[126:119] != 8'hFF
    |=> o_wb_data[63:32] == {~$past(i_src_a[127]), $past(i_src_a[126:96])})
    else $error("pairwise single subtract order wrong");
  a_pair_add_double: assert property ( // [RULE_05]
    i_issue_valid && i_op == SFA_OP_PAIRWISE_ADD_DBL && i_src_b[63:0] == '0 &&
    i_src_b[126:116] != 11'h0 && i_src_b[126:116] != 11'h7FF
    |=> o_wb_data[127:64] == $past(i_src_b[127:64]))
    else $error("pairwise double add lane 1 wrong");
  a_pair_sub_double: assert property ( // [RULE_06]
    i_issue_valid && i_op == SFA_OP_PAIRWISE_SUB_DBL && i_src_a[63:0] == '0 &&
    i_src_a[126:116] != 11'h0 && i_src_a[126:116] != 11'h7FF
    |=> o_wb_data[63:0] == {~$past(i_src_a[127]), $past(i_src_a[126:64])})
    else $error("pairwise double subtract order wrong");
  a_odd_dup_lanes: assert property ( // [RULE_07]
    i_issue_valid && i_op == SFA_OP_ODD_LANE_DUP
    |=> o_wb_data[31:0] == $past(i_src_b[63:32]) && o_wb_data[95:64] == o_wb_data[127:96])
    else $error("odd duplicate lanes wrong");
  a_even_dup_lanes: assert property ( // [RULE_08]
    i_issue_valid && i_op == SFA_OP_EVEN_LANE_DUP
    |=> o_wb_data[63:32] == $past(i_src_b[31:0]) && o_wb_data[95:64] == $past(i_src_b[95:64]))
    else $error("even duplicate lanes wrong");
  a_quad_dup_halves: assert property ( // [RULE_09]
    i_issue_valid && i_op == SFA_OP_QUAD_DUP
    |=> o_wb_data[127:64] == $past(i_src_b[63:0]) && o_wb_data[63:0] == o_wb_data[127:64])
    else $error("quad duplicate halves wrong");
  a_trunc_to_zero: assert property ( // [RULE_10]
    i_issue_valid && i_op == SFA_OP_TRUNC_INT_POP && i_src_a[63:0] == 64'hBFFC_0000_0000_0000
    |=> o_wb_data[63:0] == 64'hFFFF_FFFF_FFFF_FFFF && !o_cvt_invalid)
    else $error("truncating store did not round toward zero");
  a_lane_zero_low: assert property ( // [RULE_11]
    i_issue_valid && i_op == SFA_OP_EVEN_LANE_DUP |=> o_wb_data[31:0] == $past(i_src_b[31:0]))
    else $error("lane 0 not in low bits");
  a_rnd_nearest_cvt: assert property ( // [RULE_12]
    i_issue_valid && i_op == SFA_OP_INT_STORE_POP && i_rnd_ctl == SFA_RC_NEAR &&
    i_src_a[63:0] == 64'h3FFC_0000_0000_0000 |=> o_wb_data[63:0] == 64'h2 ##1 1'b1)
    else $error("integer store ignored rounding control");

endmodule
`default_nettype wire

// file: verification/sfa_core_model.sv
`timescale 1ns/1ps
`default_nettype none
// Register file side of the core: keeps the last write-back and counts them
module sfa_core_model (
  // Clock and reset
  input  wire logic         i_ref_clk,
  input  wire logic         i_rst_b,
  // Write-back from the unit
  input  wire logic         i_wb_valid,
  input  wire logic [127:0] i_wb_data,
  // Register file view
  output logic      [127:0] o_rf_data,
  output logic      [15:0]  o_wb_count
);
  logic [127:0] rf_q;
  logic [127:0] rf_d;
  logic [15:0]  cnt_q;
  logic [15:0]  cnt_d;

  always_comb begin
    rf_d  = rf_q;
    cnt_d = cnt_q;
    if (i_wb_valid) begin
      rf_d  = i_wb_data;
      cnt_d = cnt_q + 16'h0001;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rf_q  <= 128'h0;
      cnt_q <= 16'h0000;
    end else begin
      rf_q  <= rf_d;
      cnt_q <= cnt_d;
    end
  end

  assign o_rf_data  = rf_q;
  assign o_wb_count = cnt_q;
endmodule
`default_nettype wire

// file: verification/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  import sfa_pkg::*;
  typedef struct {
    sfa_op_e      op;
    logic [127:0] a;
    logic [127:0] b;
    logic [1:0]   rc;
    logic [127:0] exp;
    logic         inv;
  } sfa_row_s;
  localparam int NROWS = 28;
  localparam logic [127:0] SA  = 128'h40800000_40400000_40000000_3F800000;
  localparam logic [127:0] SB  = 128'h41000000_40E00000_40C00000_40A00000;
  localparam logic [127:0] DA  = 128'h40000000_00000000_3FF00000_00000000;
  localparam logic [127:0] DB  = 128'h40140000_00000000_40080000_00000000;
  localparam logic [127:0] DUP = 128'h44444444_33333333_22222222_11111111;
  localparam logic [127:0] CN  = 128'h12345678_9ABCDEF0_BFFC0000_00000000;
  localparam logic [127:0] C25 = 128'hFFFFFFFF_FFFFFFFF_40040000_00000000;
  localparam logic [127:0] CNA = 128'h00000000_00000000_7FF80000_00000000;
  localparam logic [127:0] RA  = 128'h00000000_00000000_33800000_3F800000;
  localparam logic [127:0] M1  = 128'h00000000_00000000_FFFFFFFF_FFFFFFFF;
  localparam logic [127:0] M2  = 128'h00000000_00000000_FFFFFFFF_FFFFFFFE;

  logic         clk;
  logic         rst_b;
  logic         issue_valid;
  sfa_op_e      op;
  logic [127:0] src_a;
  logic [127:0] src_b;
  logic [1:0]   rnd_ctl;
  logic         wb_valid;
  logic [127:0] wb_data;
  logic         cvt_invalid;
  logic [127:0] rf_data;
  logic [15:0]  wb_count;
  int           n_errors;
  int           samples_checked;
  sfa_row_s     rows [NROWS];

  sfa_simd_fp_unit dut (
    .i_ref_clk(clk), .i_rst_b(rst_b), .i_issue_valid(issue_valid), .i_op(op),
    .i_src_a(src_a), .i_src_b(src_b), .i_rnd_ctl(rnd_ctl), .o_wb_valid(wb_valid),
    .o_wb_data(wb_data), .o_cvt_invalid(cvt_invalid)
  );

  sfa_core_model core (
    .i_ref_clk(clk), .i_rst_b(rst_b), .i_wb_valid(wb_valid), .i_wb_data(wb_data),
    .o_rf_data(rf_data), .o_wb_count(wb_count)
  );

  function automatic sfa_row_s mk(sfa_op_e o, logic [127:0] a, logic [127:0] b,
                                  logic [1:0] rc, logic [127:0] e, logic inv);
    sfa_row_s r;
    r = '{o, a, b, rc, e, inv};
    return r;
  endfunction

  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic summarize();
    $display("checks=%0d errors=%0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Generous bound: the sequence needs well under 100 cycles
  initial begin
    #(1000 * 40);
    n_errors++;
    summarize();
  end

  initial begin
    n_errors = 0;
    samples_checked = 0;
    rst_b = 1'b0;
    issue_valid = 1'b0;
    op = SFA_OP_QUAD_DUP;
    src_a = 128'h0;
    src_b = 128'h0;
    rnd_ctl = SFA_RC_NEAR;
    rows[0]  = mk(SFA_OP_ALT_ADDSUB_SINGLE, SA, SB, SFA_RC_NEAR,
                  128'h41400000_C0800000_41000000_C0800000, 1'b0);
    rows[1]  = mk(SFA_OP_ALT_ADDSUB_DOUBLE, DA, DB, SFA_RC_NEAR,
                  128'h401C0000_00000000_C0000000_00000000, 1'b0);
    rows[2]  = mk(SFA_OP_PAIRWISE_ADD_SGL, SA, SB, SFA_RC_NEAR,
                  128'h41700000_41300000_40E00000_40400000, 1'b0);
    rows[3]  = mk(SFA_OP_PAIRWISE_SUB_SGL, SA, SB, SFA_RC_NEAR,
                  128'hBF800000_BF800000_BF800000_BF800000, 1'b0);
    rows[4]  = mk(SFA_OP_PAIRWISE_ADD_DBL, DA, DB, SFA_RC_NEAR,
                  128'h40200000_00000000_40080000_00000000, 1'b0);
    rows[5]  = mk(SFA_OP_PAIRWISE_SUB_DBL, DA, DB, SFA_RC_NEAR,
                  128'hC0000000_00000000_BFF00000_00000000, 1'b0);
    rows[6]  = mk(SFA_OP_ODD_LANE_DUP, SA, DUP, SFA_RC_NEAR,
                  128'h44444444_44444444_22222222_22222222, 1'b0);
    rows[7]  = mk(SFA_OP_EVEN_LANE_DUP, SA, DUP, SFA_RC_NEAR,
                  128'h33333333_33333333_11111111_11111111, 1'b0);
    rows[8]  = mk(SFA_OP_QUAD_DUP, SA, DUP, SFA_RC_NEAR,
                  128'h22222222_11111111_22222222_11111111, 1'b0);
    rows[9]  = mk(SFA_OP_TRUNC_INT_POP, CN, SB, SFA_RC_NEAR, M1, 1'b0);
    rows[10] = mk(SFA_OP_INT_STORE_POP, CN, SB, SFA_RC_NEAR, M2, 1'b0);
    rows[11] = mk(SFA_OP_TRUNC_INT_POP, C25, SB, SFA_RC_UP, 128'h2, 1'b0);
    rows[12] = mk(SFA_OP_INT_STORE_POP, C25, SB, SFA_RC_UP, 128'h3, 1'b0);
    rows[13] = mk(SFA_OP_INT_STORE_POP, C25, SB, SFA_RC_NEAR, 128'h2, 1'b0);
    rows[14] = mk(SFA_OP_TRUNC_INT_POP, CNA, SB, SFA_RC_NEAR,
                  128'h00000000_00000000_80000000_00000000, 1'b1);
    rows[15] = mk(SFA_OP_PAIRWISE_ADD_SGL, RA, 128'h0, SFA_RC_NEAR,
                  128'h3F800000, 1'b0);
    rows[16] = mk(SFA_OP_PAIRWISE_ADD_SGL, RA, 128'h0, SFA_RC_UP,
                  128'h3F800001, 1'b0);
    rows[17] = mk(SFA_OP_INT_STORE_POP, CN, SB, SFA_RC_ZERO, M1, 1'b0);
    rows[18] = mk(SFA_OP_INT_STORE_POP, CN, SB, SFA_RC_DOWN, M2, 1'b0);
    // Rows with a zero element reach the lane assertions in the unit
    rows[19] = mk(SFA_OP_ALT_ADDSUB_DOUBLE, DA, 128'h0, SFA_RC_NEAR, DA, 1'b0);
    rows[20] = mk(SFA_OP_PAIRWISE_ADD_SGL, SA, 128'h41000000_40E00000_00000000_40A00000,
                  SFA_RC_NEAR, 128'h41700000_40A00000_40E00000_40400000, 1'b0);
    rows[21] = mk(SFA_OP_PAIRWISE_SUB_SGL, 128'h40800000_00000000_40000000_3F800000, SB,
                  SFA_RC_NEAR, 128'hBF800000_BF800000_C0800000_BF800000, 1'b0);
    rows[22] = mk(SFA_OP_PAIRWISE_ADD_DBL, DA, 128'h40140000_00000000_00000000_00000000,
                  SFA_RC_NEAR, 128'h40140000_00000000_40080000_00000000, 1'b0);
    rows[23] = mk(SFA_OP_PAIRWISE_SUB_DBL, 128'h40000000_00000000_00000000_00000000, DB,
                  SFA_RC_NEAR, 128'hC0000000_00000000_C0000000_00000000, 1'b0);
    rows[24] = mk(SFA_OP_INT_STORE_POP, 128'h3FFC0000_00000000, SB, SFA_RC_NEAR,
                  128'h2, 1'b0);
    rows[25] = mk(SFA_OP_PAIRWISE_ADD_SGL, 128'hB3800000_BF800000, 128'h0, SFA_RC_DOWN,
                  128'hBF800001, 1'b0);
    rows[26] = mk(SFA_OP_PAIRWISE_ADD_SGL, RA, 128'h0, SFA_RC_ZERO,
                  128'h3F800000, 1'b0);
    // Two to the 63rd does not fit a signed 64-bit integer
    rows[27] = mk(SFA_OP_TRUNC_INT_POP, 128'h43E00000_00000000, SB, SFA_RC_NEAR,
                  128'h80000000_00000000, 1'b1);
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    @(negedge clk);
    chk({wb_data[127:2], wb_valid, cvt_invalid}, 128'h0);
    // Issue every row back to back; each result is looked at one cycle later
    for (int i = 0; i <= NROWS; i++) begin
      @(posedge clk);
      issue_valid <= (i < NROWS);
      if (i < NROWS) begin
        op <= rows[i].op;
        src_a <= rows[i].a;
        src_b <= rows[i].b;
        rnd_ctl <= rows[i].rc;
      end
      @(negedge clk);
      if (i > 0) begin
        chk(wb_data, rows[i-1].exp);
        chk({126'h0, wb_valid, cvt_invalid}, {126'h0, 1'b1, rows[i-1].inv});
      end
    end
    @(negedge clk);
    chk({wb_data[127:1], wb_valid}, {rows[NROWS-1].exp[127:1], 1'b0});
    chk(rf_data, rows[NROWS-1].exp);
    chk({112'h0, wb_count}, 128'(NROWS));
    // Undefined opcode answers with zero data
    @(posedge clk);
    issue_valid <= 1'b1;
    op <= sfa_op_e'(4'hF);
    @(posedge clk);
    issue_valid <= 1'b0;
    @(negedge clk);
    chk({wb_data[127:1], wb_valid}, 128'h1);
    // Reset in mid-run clears the outputs
    @(posedge clk);
    issue_valid <= 1'b1;
    op <= SFA_OP_QUAD_DUP;
    @(posedge clk);
    rst_b <= 1'b0;
    issue_valid <= 1'b0;
    @(negedge clk);
    chk({wb_data[127:2], wb_valid, cvt_invalid}, 128'h0);
    @(posedge clk);
    rst_b <= 1'b1;
    @(negedge clk);
    chk({wb_data[127:2], wb_valid, cvt_invalid}, 128'h0);
    summarize();
  end
endmodule
`default_nettype wire
